// ### gdio_pad_model.sv
/* Board side of the pads: external drivers, pull-ups, floating pins.
   A floating pin shows a level that flips every cycle. */
`timescale 1ns/1ps
`default_nettype none
module gdio_pad_model (
   input wire logic pclk,
   input wire logic [5:0] pad_out,
   input wire logic [5:0] pad_oe,
   input wire logic [5:0] pad_pullup,
   input wire logic [5:0] ext_val,
   input wire logic [5:0] ext_en,
   output logic [5:0] pad_in
);
   logic [5:0] flt = 6'h15;
   always @(posedge pclk) flt <= ~flt;
   always_comb
      for (int i = 0; i < 6; i++)
         pad_in[i] = pad_oe[i] ? pad_out[i] : ext_en[i] ? ext_val[i] : pad_pullup[i] | flt[i];
endmodule : gdio_pad_model
`default_nettype wire

// ### gdio_pin_sync.sv
/*
 * One pin's input path: sleep clamp ahead of the input buffer, a latch
 * transparent while the clock is high, then the sample flip-flop.
 * Assumes pclk is the I/O clock shared by all ports.
 */
`timescale 1ns/1ps
`default_nettype none
module gdio_pin_sync (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pad_in,
   input wire logic clamp,
   output logic sample
);
   import gdio_pkg::*;
   logic buffered;
   logic latched;

   assign buffered = pad_in & ~clamp; // (R15)

   // Sync latch holds while the clock is low.
   always_latch begin
      if (pclk) begin
         latched = buffered; // (R9)
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sample <= 1'b0;
      end else begin
         sample <= latched; // (R10)
      end
   end
endmodule : gdio_pin_sync
`default_nettype wire

// ### gdio_pkg.sv
/*
 * Package for the general digital I/O port: register offsets, field positions,
 * reset values and the carrier structs used inside the port; the pin cells take scalar signals.
 * Assumes a 32-bit APB slave with one aligned word per register.
 */
package gdio_pkg;
   localparam int GDIO_PINS = 6;
   localparam logic [11:0] GDIO_OFF_INPUT = 12'h000;
   localparam logic [11:0] GDIO_OFF_DIRECTION = 12'h004;
   localparam logic [11:0] GDIO_OFF_OUTPUT = 12'h008;
   localparam logic [11:0] GDIO_OFF_MCU_CONTROL = 12'h00C;
   localparam logic [11:0] GDIO_OFF_SLEEP = 12'h010;
   localparam logic [11:0] GDIO_OFF_EXT_INT = 12'h014;
   localparam int GDIO_PUD_BIT = 6;
   localparam logic [5:0] GDIO_DIR_RESET = 6'h00;
   localparam logic [5:0] GDIO_OUT_RESET = 6'h00;
   localparam logic GDIO_PUD_RESET = 1'b0;
   localparam int GDIO_INT_PIN = 2;

   typedef struct packed {
      logic [5:0] pad_out;
      logic [5:0] pad_oe;
      logic [5:0] pullup_en;
   } gdio_pad_drive_t;

   typedef struct packed {
      logic write_output_reg_strobe;
      logic write_input_loc_strobe;
      logic write_direction_strobe;
      logic [5:0] wdata;
   } gdio_strobes_t;
endpackage : gdio_pkg

// ### gdio_port.sv
/*
 * General digital I/O port with six pins reached over APB.
 * Assumes asynchronous pad inputs, synchronised per pin, and an external resolver for the pad wires.
 */
// Decided for this implementation: the address map and the APB interface to the registers.
// Functional notes
// (R1) Each pin has direction, output value and input sample bits in port registers.
// (R2) Direction one makes an output, zero an input.
// (R3) Input with value one enables pull-up unless globally disabled.
// (R4) Global pull-up disable turns every pull-up off.
// (R5) Output drives high for value one, low for value zero.
// (R6) Reset tri-states all pins asynchronously.
// (R7) Writing one to the input location toggles the output value bit.
// (R8) Synchronised pad level is readable whatever the direction.
// (R9) Pad passes a clock-high transparent latch then the sample flip-flop.
// (R10) External changes show in the sample after half to one and a half periods.
// (R11) Software-driven pin values read back one period after the write.
// (R12) Software inserts one idle instruction before reading back a written value.
// (R13) Software passes an intermediate state between tri-state and driven high.
// (R14) Software passes an intermediate state between pull-up input and driven low.
// (R15) Sleep clamps the digital input to ground before the buffer.
// (R16) The clamp skips a pin whose external interrupt is enabled.
// (R17) A high disabled edge interrupt pin sets its flag on wake.
// (R18) Pull-ups are off while reset is active.
// (R19) Strobes shared per port; clock, sleep and pull-up disable shared by ports.
// (R20) Unused pins should be held at a defined level, preferably by pull-up.
// (R21) Global pull-up disable is bit 6 of the control register.
// (R22) Input location is read-only storage; direction and output are read-write.
// (R23) Direction and output bits reset to zero.
`timescale 1ns/1ps
`default_nettype none
module gdio_port (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [gdio_pkg::GDIO_PINS-1:0] pad_in,
   output logic [gdio_pkg::GDIO_PINS-1:0] pad_out,
   output logic [gdio_pkg::GDIO_PINS-1:0] pad_oe,
   output logic [gdio_pkg::GDIO_PINS-1:0] pad_pullup,
   input wire logic sleep_active,
   output logic ext_int_level,
   output logic wake_int_flag_set
);
   import gdio_pkg::*;

   typedef struct packed {
      logic [5:0] direction;
      logic [5:0] out_value;
      logic global_pullup_disable;
      logic sleep_seen;
      logic ext_int_enable;
      logic ext_int_edge_mode;
      logic wake_pulse;
      logic [31:0] rdata;
   } gdio_state_t;

   gdio_state_t state;
   gdio_state_t next_state;
   gdio_strobes_t strobes;
   gdio_pad_drive_t drive;
   logic [5:0] sample;
   logic [5:0] clamp;
   logic access;
   logic wr;
   logic mapped;
   logic [31:0] rd_mux;

   assign access = psel & penable;
   assign wr = access & pwrite & pstrb[0];
   assign pready = 1'b1;
   assign mapped = (paddr == GDIO_OFF_INPUT) || (paddr == GDIO_OFF_DIRECTION) ||
      (paddr == GDIO_OFF_OUTPUT) || (paddr == GDIO_OFF_MCU_CONTROL) ||
      (paddr == GDIO_OFF_SLEEP) || (paddr == GDIO_OFF_EXT_INT);
   assign pslverr = access & ~mapped;

   // Port-wide strobes shared by all pins.
   assign strobes.write_output_reg_strobe = wr && paddr == GDIO_OFF_OUTPUT; // (R19)
   assign strobes.write_input_loc_strobe = wr && paddr == GDIO_OFF_INPUT; // (R19)
   assign strobes.write_direction_strobe = wr && paddr == GDIO_OFF_DIRECTION; // (R19)
   assign strobes.wdata = pwdata[5:0];

   // Pin drivers come straight from reset-cleared flops, so reset tri-states them at once.
   always_comb begin
      for (int i = 0; i < GDIO_PINS; i++) begin
         drive.pad_oe[i] = state.direction[i]; // (R2) (R6)
         drive.pad_out[i] = state.direction[i] & state.out_value[i]; // (R5)
         drive.pullup_en[i] = ~state.direction[i] & state.out_value[i] &
            ~state.global_pullup_disable; // (R3) (R4) (R18)
      end
   end

   assign pad_oe = drive.pad_oe;
   assign pad_out = drive.pad_out;
   assign pad_pullup = drive.pullup_en;

   always_comb begin
      for (int i = 0; i < GDIO_PINS; i++) begin
         clamp[i] = sleep_active &
            ~(i == GDIO_INT_PIN && state.ext_int_enable); // (R15) (R16)
      end
   end

   // The fed-back pad input reads a written value one period after the write.
   genvar g;
   generate
      for (g = 0; g < GDIO_PINS; g++) begin : g_pin
         gdio_pin_sync u_sync (
            .pclk(pclk),
            .presetn(presetn),
            .pad_in(pad_in[g]),
            .clamp(clamp[g]),
            .sample(sample[g])
         ); // (R8) (R11)
      end
   endgenerate

   assign ext_int_level = sample[GDIO_INT_PIN];

   always_comb begin
      rd_mux = 32'h0000_0000;
      case (paddr)
         GDIO_OFF_INPUT: rd_mux[5:0] = sample; // (R8)
         GDIO_OFF_DIRECTION: rd_mux[5:0] = state.direction; // (R22)
         GDIO_OFF_OUTPUT: rd_mux[5:0] = state.out_value; // (R22)
         GDIO_OFF_MCU_CONTROL: rd_mux[GDIO_PUD_BIT] = state.global_pullup_disable; // (R21)
         GDIO_OFF_SLEEP: rd_mux[0] = sleep_active;
         GDIO_OFF_EXT_INT: rd_mux[1:0] = {state.ext_int_edge_mode, state.ext_int_enable};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_comb begin
      next_state = state;
      next_state.wake_pulse = 1'b0;
      if (strobes.write_direction_strobe) begin
         next_state.direction = strobes.wdata; // (R1)
      end
      if (strobes.write_output_reg_strobe) begin
         next_state.out_value = strobes.wdata; // (R1)
      end else if (strobes.write_input_loc_strobe) begin
         next_state.out_value = state.out_value ^ strobes.wdata; // (R7)
      end
      if (wr && paddr == GDIO_OFF_MCU_CONTROL) begin
         next_state.global_pullup_disable = pwdata[GDIO_PUD_BIT]; // (R21)
      end
      if (wr && paddr == GDIO_OFF_EXT_INT) begin
         next_state.ext_int_enable = pwdata[0];
         next_state.ext_int_edge_mode = pwdata[1];
      end
      // On wake the clamped-low input rises, which an edge detector sees as a change.
      next_state.sleep_seen = sleep_active;
      if (state.sleep_seen && !sleep_active && !state.ext_int_enable &&
         state.ext_int_edge_mode && pad_in[GDIO_INT_PIN]) begin
         next_state.wake_pulse = 1'b1; // (R17)
      end
      if (access && !pwrite) begin
         next_state.rdata = rd_mux;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state.direction <= GDIO_DIR_RESET; // (R23) (R6)
         state.out_value <= GDIO_OUT_RESET; // (R23)
         state.global_pullup_disable <= GDIO_PUD_RESET;
         state.sleep_seen <= 1'b0;
         state.ext_int_enable <= 1'b0;
         state.ext_int_edge_mode <= 1'b0;
         state.wake_pulse <= 1'b0;
         state.rdata <= 32'h0000_0000;
      end else begin
         state <= next_state;
      end
   end

   assign wake_int_flag_set = state.wake_pulse;
   assign prdata = (access && !pwrite) ? rd_mux : state.rdata;
endmodule : gdio_port
`default_nettype wire

// ### gdio_port_checker.sv
/* Concurrent checks on the pins of gdio_port.
   Bound into gdio_port; sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module gdio_port_checker (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   input wire logic [5:0] pad_in,
   input wire logic [5:0] pad_out,
   input wire logic [5:0] pad_oe,
   input wire logic [5:0] pad_pullup,
   input wire logic sleep_active,
   input wire logic ext_int_level,
   input wire logic wake_int_flag_set
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic wen = psel && penable && pwrite && pstrb[0];
   property p_rst; (pad_oe != 0 || pad_pullup != 0) |-> $past(presetn); endproperty
   a_rst: assert property (p_rst) else $error("pad active out of reset");
   property p_dir; wen && paddr == 12'h004 |=> pad_oe == $past(pwdata[5:0]); endproperty
   a_dir: assert property (p_dir) else $error("direction not on pad_oe");
   property p_drv; wen && paddr == 12'h008 && pad_oe == 6'h3F |=> pad_out == $past(pwdata[5:0]);
   endproperty
   a_drv: assert property (p_drv) else $error("drive level wrong");
   property p_tgl; wen && paddr == 12'h000 && pad_oe == 6'h3F
      |=> pad_out == ($past(pad_out) ^ $past(pwdata[5:0])); endproperty
   a_tgl: assert property (p_tgl) else $error("toggle wrong");
   property p_pud; wen && paddr == 12'h00C && pwdata[6] |=> pad_pullup == 0; endproperty
   a_pud: assert property (p_pud) else $error("pull-up not disabled");
   property p_pu; (pad_pullup & pad_oe) == 0; endproperty
   a_pu: assert property (p_pu) else $error("pull-up on output");
   property p_rdd; psel && penable && !pwrite && paddr == 12'h004 |-> prdata[5:0] == pad_oe;
   endproperty
   a_rdd: assert property (p_rdd) else $error("direction readback wrong");
   property p_err; psel && penable && paddr > 12'h014 |-> pslverr; endproperty
   a_err: assert property (p_err) else $error("no error on unmapped");
   property p_smp; (!sleep_active && $stable(pad_in[2])) [*3] |-> ext_int_level == pad_in[2];
   endproperty
   a_smp: assert property (p_smp) else $error("sample lags pad");
   property p_wk; wake_int_flag_set
      |-> ($past(sleep_active) || $past(sleep_active, 2)) ##1 !wake_int_flag_set; endproperty
   a_wk: assert property (p_wk) else $error("wake flag wrong");
   cover property (wen && paddr == 12'h000);
   cover property (wake_int_flag_set);
   cover property (pslverr);
endmodule : gdio_port_checker
bind gdio_port gdio_port_checker u_chk (.*);
`default_nettype wire

// ### testbench.sv
/* Self-checking bench for gdio_port over APB.
   The pad model resolves every pad wire. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sleep_active = 0, w;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic [3:0] pstrb = 4'hF;
   logic pready, pslverr, ext_int_level, wake_int_flag_set, err;
   logic [5:0] pad_in, pad_out, pad_oe, pad_pullup, ext_val = 0, ext_en = 0;
   int n_mismatch = 0, comparisons = 0;
   always #20 pclk = ~pclk;
   gdio_port u_dut (.*);
   gdio_pad_model u_pad (.*);
   task chk(input string s, input logic [31:0] e, g);
      comparisons++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %s exp %h got %h", s, e, g);
      end
   endtask : chk
   task xf(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask : xf
   task close_out;
      $display("checks %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : close_out
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1;
      xf(0, 12'h004, 0);
      chk("dir", 0, rd);
      chk("err", 0, err);
      chk("oe", 0, pad_oe);
      $display("reset done");
      for (int i = 0; i < 8; i++) begin
         xf(1, 12'h00C, {25'h0, i[0], 6'h0});
         xf(1, 12'h008, {32{i[1]}});
         xf(1, 12'h004, {32{i[2]}});
         @(posedge pclk);
         chk("oe", {6{i[2]}}, pad_oe);
         chk("drv", {6{i[2] & i[1]}}, pad_out);
         chk("pu", {6{!i[2] & i[1] & !i[0]}}, pad_pullup);
      end
      $display("config done");
      xf(1, 12'h004, 0);
      xf(1, 12'h008, 0);
      xf(1, 12'h000, 32'h15);
      xf(0, 12'h008, 0);
      chk("tgl", 32'h15, rd);
      xf(1, 12'h004, 32'h3F);
      xf(1, 12'h000, 32'h3F);
      xf(0, 12'h008, 0);
      chk("tgl", 32'h2A, rd);
      xf(0, 12'h000, 0);
      chk("pin", 32'h2A, rd);
      xf(1, 12'h004, 0);
      ext_en <= 6'h3F;
      ext_val <= 6'h37;
      xf(0, 12'h000, 0);
      chk("ext", 32'h37, rd);
      xf(0, 12'h018, 0);
      chk("unmapped", 0, rd);
      chk("slverr", 1, err);
      $display("toggle and read done");
      xf(1, 12'h014, 32'h2);
      sleep_active <= 1;
      xf(0, 12'h000, 0);
      chk("clamp", 0, rd);
      sleep_active <= 0;
      w = 0;
      repeat (4) begin
         @(posedge pclk);
         w = w | wake_int_flag_set;
      end
      chk("wake", 1, w);
      xf(1, 12'h014, 32'h3);
      sleep_active <= 1;
      xf(0, 12'h000, 0);
      chk("noclamp", 32'h04, rd);
      chk("int_lvl", 1, ext_int_level);
      sleep_active <= 0;
      $display("sleep done");
      ext_en <= 0;
      xf(1, 12'h00C, 0);
      xf(1, 12'h008, 32'h3F);
      xf(1, 12'h004, 32'h0F);
      presetn <= 0;
      #1;
      chk("rst_oe", 0, pad_oe);
      chk("rst_pu", 0, pad_pullup);
      @(posedge pclk);
      presetn <= 1;
      xf(0, 12'h004, 0);
      chk("rst_dir", 0, rd);
      xf(0, 12'h008, 0);
      chk("rst_out", 0, rd);
      $display("reset in run done");
      close_out;
   end
   initial begin
      #200000;
      n_mismatch++;
      close_out;
   end
endmodule : testbench
`default_nettype wire
